/* verilog/bpsc_top.v */
// battery pack supervisor control: timing, shutdown, trip point, bus-off, modes
`timescale 1ns/1ps
`default_nettype none
`include "bpsc_defines.vh"

module bpsc_top #(
    parameter        CLK_HZ      = `BPSC_CLK_HZ,
    parameter [31:0] MS_CYCLES   = `BPSC_MS_CYCLES,
    parameter [15:0] DEB_CYCLES  = `BPSC_DEB_CYCLES,
    parameter        CELLS       = 4,
    parameter        ACC_W       = 32,
    parameter        CUR_W       = 16
) (
    // clock and reset
    input  wire                   sys_clk_i,
    input  wire                   rst_b_i,
    // pack pins
    input  wire                   system_present_n_i,
    input  wire                   emergency_off_in_i,
    input  wire                   smbus_clock_pin_i,
    input  wire                   smbus_data_pin_i,
    // measurements from the analog front end
    input  wire signed [CUR_W-1:0] sense_diff_i,
    input  wire                   sample_valid_i,
    input  wire [15:0]            remaining_charge_level_i,
    input  wire [6:0]             relative_charge_pct_i,
    input  wire                   temp_in_range_i,
    input  wire                   fault_i,
    input  wire                   second_level_fail_i,
    input  wire [7:0]             permanent_fail_code_i,
    input  wire                   records_changed_i,
    input  wire                   times_changed_i,
    // configuration
    input  wire [1:0]             power_mode_i,
    input  wire [15:0]            sleep_interval_ms_i,
    input  wire [15:0]            off_timeout_ms_i,
    input  wire                   trip_enable_i,
    input  wire [15:0]            trip_set_level_i,
    input  wire [15:0]            trip_clear_level_i,
    input  wire                   balance_external_i,
    input  wire [CELLS-1:0]       balance_request_i,
    input  wire [2:0]             led_segments_i,
    input  wire                   led_show_fail_i,
    input  wire [4:0]             temp_enable_i,
    input  wire [4:0]             temp_is_fet_i,
    input  wire [4:0]             temp_model_sel_i,
    input  wire                   broadcast_enable_i,
    input  wire                   pec_enable_i,
    input  wire                   charge_request_i,
    // outputs
    output reg                    charge_switch_drive_o,
    output reg                    discharge_switch_drive_o,
    output reg                    system_present_o,
    output reg                    trip_point_irq_o,
    output reg                    trip_pullup_en_o,
    output reg                    operation_flags_trip_o,
    output reg                    charging_o,
    output reg                    discharging_o,
    output reg  signed [ACC_W-1:0] charge_count_o,
    output reg  [CELLS-1:0]       balance_enable_o,
    output reg  [4:0]             led_o,
    output reg                    cell_update_o,
    output reg  [4:0]             temp_active_o,
    output reg  [4:0]             temp_fet_route_o,
    output reg  [4:0]             temp_model_o,
    output reg                    bus_off_o,
    output reg                    bus_active_o,
    output reg                    cycle_start_o,
    output reg                    awake_o,
    output reg                    life_log_o,
    output reg                    time_log_o,
    output reg                    fuse_blow_o,
    output reg                    broadcast_start_o,
    output reg                    broadcast_pec_o,
    output reg                    charge_allow_o
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    reg rst_s1_reg;
    reg rst_s2_reg;
    wire rst_n = rst_s2_reg;

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // millisecond tick and slow timers
    // ------------------------------------------------------------
    reg  [31:0] ms_div_reg;
    reg         ms_tick_reg;
    reg  [15:0] sec_ms_reg;
    reg  [15:0] quarter_ms_reg;
    reg  [23:0] hour_ms_reg;
    reg  [3:0]  hours_life_reg;
    reg  [1:0]  hours_time_reg;
    wire        shut_mode = (power_mode_i == `BPSC_MODE_SHUT);
    wire        sec_tick  = ms_tick_reg && (sec_ms_reg == 16'h0000);
    wire        hour_tick = ms_tick_reg && (hour_ms_reg == 24'h00_0000);

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ms_div_reg     <= 32'h0000_0000;
            ms_tick_reg    <= 1'b0;
            sec_ms_reg     <= 16'h0000;
            quarter_ms_reg <= 16'h0000;
            hour_ms_reg    <= 24'h00_0000;
        end else begin
            ms_tick_reg <= (ms_div_reg == MS_CYCLES - 32'h0000_0001);
            ms_div_reg  <= (ms_div_reg == MS_CYCLES - 32'h0000_0001) ? 32'h0000_0000
                                                                     : ms_div_reg + 32'h0000_0001;
            if (ms_tick_reg) begin
                sec_ms_reg     <= (sec_ms_reg == `BPSC_PRESENT_POLL_MS - 1) ? 16'h0000
                                                                         : sec_ms_reg + 16'h0001;
                quarter_ms_reg <= (quarter_ms_reg == `BPSC_CELL_UPD_MS - 1) ? 16'h0000
                                                                            : quarter_ms_reg + 16'h0001;
                hour_ms_reg    <= (hour_ms_reg == `BPSC_HOUR_LAST_MS) ? 24'h00_0000
                                                               : hour_ms_reg + 24'h00_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // input synchronisers and debouncers
    // ------------------------------------------------------------
    reg [1:0]  off_sync_reg;
    reg [1:0]  present_sync_reg;
    reg        off_deb_reg;
    reg        present_deb_reg;
    reg [15:0] off_cnt_reg;
    reg [15:0] present_cnt_reg;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            off_sync_reg  <= 2'b11;
            present_sync_reg <= 2'b11;
            off_deb_reg      <= 1'b1;
            present_deb_reg  <= 1'b1;
            off_cnt_reg      <= 16'h0000;
            present_cnt_reg  <= 16'h0000;
        end else begin
            off_sync_reg     <= {off_sync_reg[0], emergency_off_in_i};
            present_sync_reg <= {present_sync_reg[0], system_present_n_i};
            // level must hold for the debounce count before it is accepted
            if (off_sync_reg[1] == off_deb_reg)
                off_cnt_reg <= 16'h0000;
            else if (off_cnt_reg == DEB_CYCLES) begin
                off_deb_reg <= off_sync_reg[1];
                off_cnt_reg <= 16'h0000;
            end else
                off_cnt_reg <= off_cnt_reg + 16'h0001;
            if (present_sync_reg[1] == present_deb_reg)
                present_cnt_reg <= 16'h0000;
            else if (present_cnt_reg == DEB_CYCLES) begin
                present_deb_reg <= present_sync_reg[1];
                present_cnt_reg <= 16'h0000;
            end else
                present_cnt_reg <= present_cnt_reg + 16'h0001;
        end
    end

    wire off_fall = off_deb_reg && (off_sync_reg[1] == 1'b0) && (off_cnt_reg == DEB_CYCLES);

    // ------------------------------------------------------------
    // emergency shutdown, fuse and switch drives
    // ------------------------------------------------------------
    reg        eoff_reg;
    reg [15:0] eoff_ms_reg;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            eoff_reg    <= 1'b0;
            eoff_ms_reg <= 16'h0000;
            fuse_blow_o <= 1'b0;
        end else begin
            if (second_level_fail_i)
                fuse_blow_o <= 1'b1;
            if (off_fall && !shut_mode) begin
                eoff_reg    <= ~eoff_reg;
                eoff_ms_reg <= 16'h0000;
            end else if (eoff_reg && ms_tick_reg) begin
                // a timeout of zero means the drives stay off until the next press
                if (off_timeout_ms_i != 16'h0000 && eoff_ms_reg == off_timeout_ms_i - 16'h0001)
                    eoff_reg <= 1'b0;
                eoff_ms_reg <= eoff_ms_reg + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // measurement, accumulation and cycle scheduling
    // ------------------------------------------------------------
    reg [15:0] cyc_ms_reg;
    wire [15:0] interval = (power_mode_i == `BPSC_MODE_SLEEP) ? sleep_interval_ms_i
                                                              : `BPSC_CYCLE_MS;
    wire wake = (sample_valid_i && sense_diff_i != {CUR_W{1'b0}}) || fault_i;
    wire signed [ACC_W-1:0] cur_ext = {{(ACC_W-CUR_W){sense_diff_i[CUR_W-1]}}, sense_diff_i};
    wire trip_hit = remaining_charge_level_i <= trip_set_level_i;
    wire trip_rel = remaining_charge_level_i > trip_clear_level_i;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cyc_ms_reg               <= 16'h0000;
            cycle_start_o            <= 1'b0;
            awake_o                  <= 1'b1;
            charge_count_o           <= {ACC_W{1'b0}};
            charging_o               <= 1'b0;
            discharging_o            <= 1'b0;
            system_present_o         <= 1'b0;
            cell_update_o            <= 1'b0;
            charge_switch_drive_o    <= 1'b0;
            discharge_switch_drive_o <= 1'b0;
            charge_allow_o           <= 1'b0;
            trip_point_irq_o         <= 1'b0;
            operation_flags_trip_o   <= 1'b0;
            trip_pullup_en_o         <= 1'b0;
            balance_enable_o         <= {CELLS{1'b0}};
            led_o                    <= 5'h00;
            temp_active_o            <= 5'h00;
            temp_fet_route_o         <= 5'h00;
            temp_model_o             <= 5'h00;
            broadcast_start_o        <= 1'b0;
            broadcast_pec_o          <= 1'b0;
            life_log_o               <= 1'b0;
            time_log_o               <= 1'b0;
            hours_life_reg           <= 4'h0;
            hours_time_reg           <= 2'h0;
        end else begin
            cycle_start_o     <= 1'b0;
            cell_update_o     <= 1'b0;
            broadcast_start_o <= 1'b0;
            life_log_o        <= 1'b0;
            time_log_o        <= 1'b0;
            if (shut_mode) begin
                // cycles, measurement and logging halt; drives open and no activity
                cyc_ms_reg               <= 16'h0000;
                awake_o                  <= 1'b0;
                charge_switch_drive_o    <= 1'b0;
                discharge_switch_drive_o <= 1'b0;
                charge_allow_o           <= 1'b0;
                balance_enable_o         <= {CELLS{1'b0}};
            end else begin
                if (ms_tick_reg)
                    cyc_ms_reg <= (cyc_ms_reg >= interval - 16'h0001) ? 16'h0000
                                                                      : cyc_ms_reg + 16'h0001;
                if (ms_tick_reg && cyc_ms_reg >= interval - 16'h0001) begin
                    cycle_start_o <= 1'b1;
                    broadcast_start_o <= broadcast_enable_i;
                    broadcast_pec_o   <= pec_enable_i;
                end
                // sleep exits on current or fault; normal is always awake between cycles
                if (power_mode_i == `BPSC_MODE_SLEEP)
                    awake_o <= wake;
                else
                    awake_o <= 1'b1;
                if (sample_valid_i) begin
                    charge_count_o <= charge_count_o + cur_ext;
                    charging_o     <= !sense_diff_i[CUR_W-1] && sense_diff_i != 0;
                    discharging_o  <= sense_diff_i[CUR_W-1];
                end
                if (sec_tick)
                    system_present_o <= !present_deb_reg;
                if (ms_tick_reg && quarter_ms_reg == 16'h0000)
                    cell_update_o <= 1'b1;
                charge_allow_o <= charge_request_i && temp_in_range_i
                                  && !eoff_reg && !fuse_blow_o;
                charge_switch_drive_o    <= !eoff_reg && !fuse_blow_o
                                            && temp_in_range_i;
                discharge_switch_drive_o <= !eoff_reg && !fuse_blow_o;
                // external balancing keeps only the lowest requested cell
                if (balance_external_i)
                    balance_enable_o <= balance_request_i & (~balance_request_i + 1'b1);
                else
                    balance_enable_o <= balance_request_i;
                if (!trip_enable_i) begin
                    trip_point_irq_o       <= 1'b0;
                    operation_flags_trip_o <= 1'b0;
                end else if (trip_hit) begin
                    trip_point_irq_o       <= 1'b1;
                    operation_flags_trip_o <= 1'b1;
                end else if (trip_rel) begin
                    trip_point_irq_o       <= 1'b0;
                    operation_flags_trip_o <= 1'b0;
                end
                trip_pullup_en_o <= trip_enable_i;
                temp_active_o    <= temp_enable_i;
                temp_fet_route_o <= temp_is_fet_i & temp_enable_i;
                temp_model_o     <= temp_model_sel_i & temp_enable_i;
                if (hour_tick) begin
                    hours_life_reg <= (hours_life_reg == `BPSC_LIFE_LOG_H - 1) ? 4'h0
                                                                             : hours_life_reg + 4'h1;
                    hours_time_reg <= (hours_time_reg == `BPSC_TIME_LOG_H - 1) ? 2'h0
                                                                             : hours_time_reg + 2'h1;
                    life_log_o <= (hours_life_reg == `BPSC_LIFE_LOG_H - 1) && records_changed_i;
                    time_log_o <= (hours_time_reg == `BPSC_TIME_LOG_H - 1) && times_changed_i;
                end
                led_o <= led_bar(led_show_fail_i, permanent_fail_code_i,
                                 relative_charge_pct_i, led_segments_i);
            end
        end
    end

    // ------------------------------------------------------------
    // led bar: capacity fill or fail code, masked to three, four or else five segments
    // ------------------------------------------------------------
    function [4:0] led_bar;
        input       show_fail;
        input [7:0] code;
        input [6:0] pct;
        input [2:0] segs;
        reg   [4:0] mask;
        reg   [4:0] fill;
        integer     lit;
        begin
            mask = (segs == 3'd3) ? 5'h07 : (segs == 3'd4) ? 5'h0F : 5'h1F;
            lit  = (pct * segs + 99) / 100;
            fill = (5'h1F >> (5 - lit));
            if (pct == 7'd0)
                fill = 5'h00;
            led_bar = (show_fail ? code[4:0] : fill) & mask;
        end
    endfunction

    // ------------------------------------------------------------
    // SMBus bus-off detector
    // ------------------------------------------------------------
    reg [15:0] low_ms_reg;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            low_ms_reg   <= 16'h0000;
            bus_off_o    <= 1'b0;
            bus_active_o <= 1'b0;
        end else if (shut_mode) begin
            low_ms_reg   <= 16'h0000;
            bus_active_o <= 1'b0;
        end else if (smbus_clock_pin_i || smbus_data_pin_i) begin
            // release is seen in one cycle, well inside the resume bound
            low_ms_reg   <= 16'h0000;
            bus_off_o    <= 1'b0;
            bus_active_o <= 1'b1;
        end else if (ms_tick_reg) begin
            if (low_ms_reg >= `BPSC_BUSOFF_MS - 1) begin
                bus_off_o    <= 1'b1;
                bus_active_o <= 1'b0;
            end else
                low_ms_reg <= low_ms_reg + 16'h0001;
        end
    end

endmodule // bpsc_top

`default_nettype wire

/* verilog/bpsc_defines.vh */
// constants for the battery pack supervisor control block
`ifndef BPSC_DEFINES_VH
`define BPSC_DEFINES_VH

`define BPSC_CLK_HZ          40000000
// timing figures in their own units
`define BPSC_PRESENT_POLL_MS 1000
`define BPSC_CYCLE_MS        16'h00FA
`define BPSC_CELL_UPD_MS     250
`define BPSC_BUSOFF_MS       2000
`define BPSC_RESUME_US       1
`define BPSC_LIFE_LOG_H      10
`define BPSC_TIME_LOG_H      2
// last millisecond count of one hour
`define BPSC_HOUR_LAST_MS    24'h36_EE7F
// cycles per millisecond derived from the clock
`define BPSC_MS_CYCLES       (`BPSC_CLK_HZ / 1000)
`define BPSC_DEB_CYCLES      16
// power modes
`define BPSC_MODE_NORMAL     2'h0
`define BPSC_MODE_SLEEP      2'h1
`define BPSC_MODE_SHUT       2'h2
// thermistor slots and the largest number of led bar segments
`define BPSC_TEMP_INPUTS     5
`define BPSC_LED_MAX         5

`endif

/* dv/bpsc_sva.sv */
// port-level assertion checker for the pack supervisor control block
`timescale 1ns/1ps
`default_nettype none
module bpsc_sva #(
    parameter CELLS = 4,
    parameter CUR_W = 16
) (
    // clock, reset and watched ports
    input wire logic                    sys_clk_i,
    input wire logic                    rst_b_i,
    input wire logic                    second_level_fail_i,
    input wire logic                    fuse_blow_o,
    input wire logic                    charge_switch_drive_o,
    input wire logic                    discharge_switch_drive_o,
    input wire logic                    sample_valid_i,
    input wire logic signed [CUR_W-1:0] sense_diff_i,
    input wire logic                    charging_o,
    input wire logic                    discharging_o,
    input wire logic                    balance_external_i,
    input wire logic [CELLS-1:0]        balance_enable_o,
    input wire logic                    trip_enable_i,
    input wire logic                    trip_pullup_en_o,
    input wire logic                    bus_off_o,
    input wire logic                    bus_active_o,
    input wire logic                    smbus_clock_pin_i,
    input wire logic                    smbus_data_pin_i,
    input wire logic [1:0]              power_mode_i,
    input wire logic                    cycle_start_o,
    input wire logic                    temp_in_range_i,
    input wire logic                    charge_allow_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_fuse; second_level_fail_i |-> ##[1:4] fuse_blow_o; endproperty
    a_fuse: assert property (p_fuse) else $error("fuse output not raised");
    property p_fuse_off; fuse_blow_o |-> ##2 !(charge_switch_drive_o || discharge_switch_drive_o);
    endproperty
    a_fuse_off: assert property (p_fuse_off) else $error("drives on after fuse");
    property p_charging; sample_valid_i && sense_diff_i > 0 |=> charging_o; endproperty
    a_charging: assert property (p_charging) else $error("positive sample not charging");
    property p_discharging; sample_valid_i && sense_diff_i < 0 |=> discharging_o; endproperty
    a_discharging: assert property (p_discharging) else $error("negative sample not discharging");
    property p_bal; balance_external_i [*2] |-> $countones(balance_enable_o) <= 1; endproperty
    a_bal: assert property (p_bal) else $error("several external bypasses on");
    property p_pull; (!trip_enable_i) [*3] |-> !trip_pullup_en_o; endproperty
    a_pull: assert property (p_pull) else $error("pull-up on while trip idle");
    property p_shut; (power_mode_i == 2'h2) [*3] |-> !cycle_start_o; endproperty
    a_shut: assert property (p_shut) else $error("cycle started in shutdown");
    property p_exit;
        bus_off_o && (smbus_clock_pin_i || smbus_data_pin_i) |-> ##[1:4] (bus_active_o && !bus_off_o);
    endproperty
    a_exit: assert property (p_exit) else $error("bus did not resume");
    property p_temp; (!temp_in_range_i) [*3] |-> !charge_allow_o; endproperty
    a_temp: assert property (p_temp) else $error("charge allowed out of range");
    c_off: cover property (bus_off_o);
    c_fuse: cover property (fuse_blow_o);
    c_charging: cover property ($rose(charging_o));
endmodule // bpsc_sva
bind bpsc_top bpsc_sva #(.CELLS(CELLS), .CUR_W(CUR_W)) u_bpsc_sva (.*);
`default_nettype wire

/* dv/bpsc_host_model.sv */
// host and charger stand-in that owns the two bus lines
`timescale 1ns/1ps
`default_nettype none
module bpsc_host_model (
    input  wire logic sys_clk_i,
    input  wire logic hold_low_i,
    output var  logic smbus_clock_pin_o = 1'b1,
    output var  logic smbus_data_pin_o  = 1'b1
);
    // released lines rise through the pull-ups, so idle is high
    always @(posedge sys_clk_i) begin
        smbus_clock_pin_o <= !hold_low_i;
        smbus_data_pin_o  <= !hold_low_i;
    end
endmodule // bpsc_host_model
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the pack supervisor control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk_i = 0, rst_b_i = 0, hold_low = 0, system_present_n_i = 1;
    logic emergency_off_in_i = 1, sample_valid_i = 0, temp_in_range_i = 1, fault_i = 0;
    logic second_level_fail_i = 0, records_changed_i = 0, times_changed_i = 0;
    logic trip_enable_i = 0, balance_external_i = 0, led_show_fail_i = 0;
    logic broadcast_enable_i = 1, pec_enable_i = 1, charge_request_i = 1;
    logic signed [15:0] sense_diff_i = 16'h0000;
    logic [15:0] remaining_charge_level_i = 16'h0190, sleep_interval_ms_i = 16'h000A;
    logic [15:0] off_timeout_ms_i = 16'h0000, trip_set_level_i = 16'h0064;
    logic [15:0] trip_clear_level_i = 16'h00C8;
    logic [6:0] relative_charge_pct_i = 7'h32;
    logic [7:0] permanent_fail_code_i = 8'hFF;
    logic [4:0] temp_enable_i = 5'h1F, temp_is_fet_i = 5'h00, temp_model_sel_i = 5'h00;
    logic [3:0] balance_request_i = 4'hB;
    logic [2:0] led_segments_i = 3'h3;
    logic [1:0] power_mode_i = 2'h0;
    wire logic smbus_clock_pin_i, smbus_data_pin_i;
    logic charge_switch_drive_o, discharge_switch_drive_o, system_present_o, trip_point_irq_o;
    logic trip_pullup_en_o, operation_flags_trip_o, charging_o, discharging_o, cell_update_o;
    logic bus_off_o, bus_active_o, cycle_start_o, awake_o, life_log_o, time_log_o;
    logic fuse_blow_o, broadcast_start_o, broadcast_pec_o, charge_allow_o;
    logic signed [31:0] charge_count_o;
    logic [3:0] balance_enable_o;
    logic [4:0] led_o, temp_active_o, temp_fet_route_o, temp_model_o;
    int failures = 0, total_checks = 0, n;
    // short ms and debounce counts keep the run small
    bpsc_top #(.MS_CYCLES(32'h0000_0004), .DEB_CYCLES(16'h0002)) u_bpsc_top (.*);
    bpsc_host_model u_bpsc_host_model (.sys_clk_i(sys_clk_i), .hold_low_i(hold_low),
        .smbus_clock_pin_o(smbus_clock_pin_i), .smbus_data_pin_o(smbus_data_pin_i));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic ok, input bit stop);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("FAIL %0t unexpected port value", $time);
            if (stop) test_done();
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    task automatic press();
        @(posedge sys_clk_i) emergency_off_in_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        emergency_off_in_i <= 1'b1;
        wt(8);
    endtask
    task automatic gap(output int k);
        k = 0;
        repeat (1100) if (cycle_start_o !== 1'b1) wt(1);
        wt(1);
        repeat (1100) if (cycle_start_o !== 1'b1) begin k++; wt(1); end
    endtask
    task automatic t_drives();
        repeat (40) if (charge_switch_drive_o !== 1'b1) wt(1);
        chk(charge_switch_drive_o & discharge_switch_drive_o, 1);
        press();
        chk(!charge_switch_drive_o & !discharge_switch_drive_o, 0);
        press();
        chk(charge_switch_drive_o & discharge_switch_drive_o, 0);
        @(posedge sys_clk_i) off_timeout_ms_i <= 16'h0005;
        press();
        chk(!charge_switch_drive_o & !discharge_switch_drive_o, 0);
        repeat (40) if (charge_switch_drive_o !== 1'b1) wt(1);
        chk(charge_switch_drive_o & discharge_switch_drive_o, 1);
        @(posedge sys_clk_i) temp_in_range_i <= 1'b0;
        wt(6);
        chk(!charge_allow_o & !charge_switch_drive_o, 0);
        @(posedge sys_clk_i) temp_in_range_i <= 1'b1;
    endtask
    task automatic t_meas();
        chk(balance_enable_o === 4'hB, 0);
        @(posedge sys_clk_i) balance_external_i <= 1'b1;
        wt(4);
        chk(balance_enable_o === 4'h1, 0);
        @(posedge sys_clk_i) {sense_diff_i, sample_valid_i} <= {16'h0064, 1'b1};
        repeat (2) @(posedge sys_clk_i);
        sense_diff_i <= -16'sh0064;
        wt(1);
        chk(charging_o & !discharging_o, 0);
        @(posedge sys_clk_i) sample_valid_i <= 1'b0;
        wt(3);
        chk(discharging_o & !charging_o, 0);
        chk(charge_count_o === 32'sh0000_0064, 0);
        // half charge on a three-segment bar lights two segments
        chk(led_o === 5'h03, 0);
        @(posedge sys_clk_i);
        {led_show_fail_i, temp_enable_i, temp_is_fet_i, temp_model_sel_i} <= 16'h9543;
        wt(10);
        chk(led_o === 5'h07, 0);
        chk({temp_active_o, temp_fet_route_o, temp_model_o} === 15'h1401, 0);
    endtask
    task automatic t_trip();
        @(posedge sys_clk_i) trip_enable_i <= 1'b1;
        wt(4);
        chk(trip_pullup_en_o & !trip_point_irq_o, 0);
        @(posedge sys_clk_i) remaining_charge_level_i <= 16'h0032;
        wt(4);
        chk(trip_point_irq_o & operation_flags_trip_o, 0);
        @(posedge sys_clk_i) remaining_charge_level_i <= 16'h0096;
        wt(4);
        chk(trip_point_irq_o === 1'b1, 0);
        @(posedge sys_clk_i) remaining_charge_level_i <= 16'h012C;
        wt(4);
        chk(!trip_point_irq_o & !operation_flags_trip_o, 0);
    endtask
    task automatic t_bus();
        @(posedge sys_clk_i) system_present_n_i <= 1'b0;
        hold_low <= 1'b1;
        wt(7900);
        chk(bus_off_o === 1'b0, 0);
        chk(system_present_o === 1'b1, 0);
        repeat (300) if (bus_off_o !== 1'b1) wt(1);
        chk(bus_off_o === 1'b1, 1);
        @(posedge sys_clk_i) hold_low <= 1'b0;
        wt(6);
        chk(bus_active_o & !bus_off_o, 0);
    endtask
    task automatic t_cycle();
        // two quarter-second periods of 1000 cycles each at the short ms
        n = 0;
        repeat (2000) begin
            wt(1);
            n += cell_update_o;
        end
        chk(n == 2, 0);
        gap(n);
        chk(n == 999 && broadcast_start_o && broadcast_pec_o, 0);
        @(posedge sys_clk_i) power_mode_i <= 2'h1;
        gap(n);
        gap(n);
        chk(n == 39, 0);
        chk(awake_o === 1'b0, 0);
        @(posedge sys_clk_i) fault_i <= 1'b1;
        wt(2);
        chk(awake_o === 1'b1, 0);
        @(posedge sys_clk_i) {fault_i, power_mode_i} <= 3'b010;
        gap(n);
        chk(n == 1100 && !bus_active_o, 0);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        wt(6);
        chk(system_present_o === 1'b0, 0);
        t_meas();
        t_drives();
        t_trip();
        t_bus();
        t_cycle();
        // back to normal mode so that only the fuse can hold the drives off
        @(posedge sys_clk_i) {second_level_fail_i, power_mode_i} <= 3'b100;
        wt(10);
        chk(fuse_blow_o & !charge_switch_drive_o & !discharge_switch_drive_o, 0);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
